/* shared/ucs_pkg.sv */
// Package with constants and types for the unified cache and SRAM block.
package ucs_pkg;
   localparam int unsigned WORD_W       = 32;
   localparam int unsigned TAG_W        = 15;
   localparam int unsigned LINE_WORDS   = 4;
   localparam int unsigned NUM_LINES    = 256;
   localparam int unsigned SETS_W       = 8;
   // Configuration bit positions of the system_config_register.
   localparam int unsigned CFG_EN_BIT   = 1;
   localparam int unsigned CFG_SIZE_LO  = 4;
   localparam int unsigned CFG_SIZE_HI  = 5;
   localparam int unsigned CFG_BASE_LO  = 6;
   localparam int unsigned CFG_BASE_HI  = 15;
   localparam logic [1:0]  SIZE_0K      = 2'h0;
   localparam logic [1:0]  SIZE_4K      = 2'h1;
   localparam logic [1:0]  SIZE_8K      = 2'h2;
   // Set-state encodings.
   localparam logic [1:0]  CS_NONE      = 2'h0;
   localparam logic [1:0]  CS_W0        = 2'h1;
   localparam logic [1:0]  CS_BOTH      = 2'h3;
   localparam logic [1:0]  CS_REPL0     = 2'h2;
   // Address map.
   localparam logic [31:0] WAY0_BASE    = 32'h1000_0000;
   localparam logic [31:0] WAY1_BASE    = 32'h1080_0000;
   localparam logic [31:0] TAG_BASE     = 32'h1100_0000;
   localparam int unsigned WIN_HI       = 27;
   localparam int unsigned WIN_LO       = 23;
   localparam int unsigned NC_BIT       = 26;
   localparam int unsigned TAGW_V0_BIT  = 31;
   localparam int unsigned TAGW_V1_BIT  = 30;
   localparam int unsigned REG_CFG      = 0;
   localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_CLEAR = 5'b00010,
      ST_FILL  = 5'b00100,
      ST_BYP   = 5'b01000,
      ST_DONE  = 5'b10000
   } ucs_state_t;
endpackage : ucs_pkg

/* src/ucs_repl.sv */
// Replacement step of the two-way pseudo-LRU set-state.
`timescale 1ns/1ps
module ucs_repl (
   input  wire logic [1:0] CS_IN,
   output logic            VICTIM,
   output logic [1:0]      CS_OUT
);
   always_comb begin
      case (CS_IN)
         ucs_pkg::CS_NONE: begin
            VICTIM = 1'b0;
            CS_OUT = ucs_pkg::CS_W0;
         end
         ucs_pkg::CS_W0: begin
            VICTIM = 1'b1;
            CS_OUT = ucs_pkg::CS_BOTH;
         end
         ucs_pkg::CS_BOTH: begin
            VICTIM = 1'b0;
            CS_OUT = ucs_pkg::CS_REPL0;
         end
         default: begin
            VICTIM = 1'b1;
            CS_OUT = ucs_pkg::CS_W0;
         end
      endcase
   end
endmodule : ucs_repl

/* src/ucs_cache.sv */
// Unified two-way instruction/data cache with SRAM mode and direct array access.
`timescale 1ns/1ps
module ucs_cache #(
   parameter int unsigned LINES = ucs_pkg::NUM_LINES
) (
   input  wire logic        CLK,
   input  wire logic        RESET,
   // Register port for the system_config_register.
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   // Processor side.
   input  wire logic        CPU_REQ,
   input  wire logic        CPU_WE,
   input  wire logic [31:0] CPU_ADDR,
   input  wire logic [31:0] CPU_WDATA,
   output logic             CPU_ACK,
   output logic [31:0]      CPU_RDATA,
   output logic             CPU_BUSY,
   // External memory controller side.
   output logic             MEM_REQ,
   output logic             MEM_WE,
   output logic [31:0]      MEM_ADDR,
   output logic [31:0]      MEM_WDATA,
   input  wire logic        MEM_ACK,
   input  wire logic [31:0] MEM_RDATA
);
   if (LINES != ucs_pkg::NUM_LINES) begin : g_lines_chk
      $error("LINES must be 256");
   end

   localparam int unsigned DW = LINES * ucs_pkg::LINE_WORDS;

   logic [31:0] way_zero [DW];
   logic [31:0] way_one  [DW];
   logic [ucs_pkg::TAG_W-1:0] tag0 [LINES];
   logic [ucs_pkg::TAG_W-1:0] tag1 [LINES];
   logic [1:0]  cs [LINES];
   // Set-state 01 alone cannot tell a half-filled line from the steady state, so valid bits stay apart.
   logic [1:0]  vld [LINES];

   logic [31:0] cfg_r;
   ucs_pkg::ucs_state_t state_r;
   logic [7:0]  clr_idx_r;
   logic [1:0]  wcnt_r;
   logic        victim_r;
   logic [1:0]  ncs_r;
   logic [31:0] addr_r;
   logic        we_r;
   logic [31:0] wdata_r;

   logic [31:0] reg_rdata_r;
   logic        busy_r;
   logic        cpu_ack_r;
   logic [31:0] cpu_rdata_r;
   logic        mem_req_r;
   logic        mem_we_r;
   logic [31:0] mem_addr_r;
   logic [31:0] mem_wdata_r;

   // Index and tag split of an address; used on both lookup and fill.
   function automatic logic [7:0] f_set(input logic [31:0] a);
      f_set = a[11:4];
   endfunction : f_set
   function automatic logic [ucs_pkg::TAG_W-1:0] f_tag(input logic [31:0] a);
      f_tag = a[26:12];
   endfunction : f_tag
   function automatic logic [9:0] f_widx(input logic [31:0] a);
      f_widx = a[11:2];
   endfunction : f_widx

   // Lookup.
   logic [1:0]  cs_cur;
   logic [1:0]  vld_cur;
   logic [1:0]  repl_in;
   logic        hit0;
   logic        hit1;
   logic        en_cache;
   logic        one_way;
   logic        in_sram;
   logic [4:0]  win;
   logic        victim_c;
   logic [1:0]  ncs_c;
   logic        is_win;

   assign win     = CPU_ADDR[ucs_pkg::WIN_HI:ucs_pkg::WIN_LO];
   assign is_win  = (CPU_ADDR[31:28] == ucs_pkg::WAY0_BASE[31:28]) && (win[4:3] == 2'h0);
   assign cs_cur  = cs[f_set(CPU_ADDR)];
   assign vld_cur = vld[f_set(CPU_ADDR)];
   assign en_cache = cfg_r[ucs_pkg::CFG_EN_BIT] &&
                     (cfg_r[ucs_pkg::CFG_SIZE_HI:ucs_pkg::CFG_SIZE_LO] != ucs_pkg::SIZE_0K);
   assign one_way = cfg_r[ucs_pkg::CFG_SIZE_HI:ucs_pkg::CFG_SIZE_LO] == ucs_pkg::SIZE_4K;
   // SRAM region starts at the configured 64 Kbyte pointer and spans what the cache leaves.
   assign in_sram = (CPU_ADDR[25:16] == cfg_r[ucs_pkg::CFG_BASE_HI:ucs_pkg::CFG_BASE_LO]) &&
                    (CPU_ADDR[31:26] == 6'h00) && (CPU_ADDR[15:13] == 3'h0) &&
                    (!en_cache || (one_way && CPU_ADDR[12]));
   assign hit0 = vld_cur[0] && (tag0[f_set(CPU_ADDR)] == f_tag(CPU_ADDR));
   assign hit1 = !one_way && vld_cur[1] && (tag1[f_set(CPU_ADDR)] == f_tag(CPU_ADDR));
   // A line back at 01 with way one still valid is in the steady state and evicts way zero.
   assign repl_in = one_way ? (cs_cur == ucs_pkg::CS_NONE ? cs_cur : ucs_pkg::CS_BOTH) :
                    (cs_cur == ucs_pkg::CS_W0 && vld_cur[1]) ? ucs_pkg::CS_BOTH : cs_cur;

   ucs_repl u_repl (
      .CS_IN  (repl_in),
      .VICTIM (victim_c),
      .CS_OUT (ncs_c)
   );

   // Configuration register.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         cfg_r <= ucs_pkg::CFG_RESET;
      end else if (REG_WR && REG_ADDR == 4'(ucs_pkg::REG_CFG)) begin
         cfg_r <= REG_WDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         reg_rdata_r <= 32'h0000_0000;
      end else begin
         reg_rdata_r <= (REG_RD && REG_ADDR == 4'(ucs_pkg::REG_CFG)) ? cfg_r : 32'h0000_0000;
      end
   end

   // Main sequencer.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_r     <= ucs_pkg::ST_CLEAR;
         busy_r      <= 1'b1;
         clr_idx_r   <= 8'h00;
         wcnt_r      <= 2'h0;
         victim_r    <= 1'b0;
         ncs_r       <= 2'h0;
         addr_r      <= 32'h0000_0000;
         we_r        <= 1'b0;
         wdata_r     <= 32'h0000_0000;
         cpu_ack_r   <= 1'b0;
         cpu_rdata_r <= 32'h0000_0000;
         mem_req_r   <= 1'b0;
         mem_we_r    <= 1'b0;
         mem_addr_r  <= 32'h0000_0000;
         mem_wdata_r <= 32'h0000_0000;
      end else begin
         cpu_ack_r <= 1'b0;
         case (state_r)
            ucs_pkg::ST_CLEAR: begin
               cs[clr_idx_r] <= ucs_pkg::CS_NONE;
               vld[clr_idx_r] <= 2'h0;
               tag0[clr_idx_r] <= '0;
               tag1[clr_idx_r] <= '0;
               clr_idx_r <= clr_idx_r + 8'h01;
               if (clr_idx_r == 8'(LINES - 1)) begin
                  state_r <= ucs_pkg::ST_IDLE;
                  busy_r  <= 1'b0;
               end
            end
            ucs_pkg::ST_IDLE: begin
               if (CPU_REQ) begin
                  addr_r  <= CPU_ADDR;
                  we_r    <= CPU_WE;
                  wdata_r <= CPU_WDATA;
                  if (is_win) begin
                     cpu_ack_r <= 1'b1;
                     case (win[2:0])
                        3'h0: begin
                           if (CPU_WE) way_zero[f_widx(CPU_ADDR)] <= CPU_WDATA;
                           cpu_rdata_r <= way_zero[f_widx(CPU_ADDR)];
                        end
                        3'h1: begin
                           if (CPU_WE) way_one[f_widx(CPU_ADDR)] <= CPU_WDATA;
                           cpu_rdata_r <= way_one[f_widx(CPU_ADDR)];
                        end
                        3'h2: begin
                           if (CPU_WE) begin
                              // Bit 31 holds way zero valid, bit 30 way one valid.
                              // The set-state is rebuilt so that the next fill lands in an empty way.
                              cs[CPU_ADDR[9:2]] <= {CPU_WDATA[ucs_pkg::TAGW_V1_BIT],
                                                    CPU_WDATA[ucs_pkg::TAGW_V0_BIT] |
                                                    CPU_WDATA[ucs_pkg::TAGW_V1_BIT]};
                              vld[CPU_ADDR[9:2]] <= {CPU_WDATA[ucs_pkg::TAGW_V1_BIT],
                                                     CPU_WDATA[ucs_pkg::TAGW_V0_BIT]};
                              tag0[CPU_ADDR[9:2]] <= CPU_WDATA[14:0];
                              tag1[CPU_ADDR[9:2]] <= CPU_WDATA[29:15];
                           end
                           cpu_rdata_r <= {vld[CPU_ADDR[9:2]][0], vld[CPU_ADDR[9:2]][1],
                                           tag1[CPU_ADDR[9:2]], tag0[CPU_ADDR[9:2]]};
                        end
                        default: cpu_rdata_r <= 32'h0000_0000;
                     endcase
                  end else if (in_sram) begin
                     cpu_ack_r <= 1'b1;
                     // Address bit 12 picks the array, so a cache-off region spans both ways.
                     if (CPU_ADDR[12]) begin
                        if (CPU_WE) way_one[f_widx(CPU_ADDR)] <= CPU_WDATA;
                        cpu_rdata_r <= way_one[f_widx(CPU_ADDR)];
                     end else begin
                        if (CPU_WE) way_zero[f_widx(CPU_ADDR)] <= CPU_WDATA;
                        cpu_rdata_r <= way_zero[f_widx(CPU_ADDR)];
                     end
                  end else if (!en_cache || CPU_ADDR[ucs_pkg::NC_BIT] || CPU_WE) begin
                     // Writes go through to memory; a cached copy is updated on a hit.
                     if (CPU_WE && en_cache && !CPU_ADDR[ucs_pkg::NC_BIT]) begin
                        if (hit0) way_zero[{f_set(CPU_ADDR), CPU_ADDR[3:2]}] <= CPU_WDATA;
                        if (hit1) way_one[{f_set(CPU_ADDR), CPU_ADDR[3:2]}] <= CPU_WDATA;
                     end
                     mem_req_r   <= 1'b1;
                     mem_we_r    <= CPU_WE;
                     mem_addr_r  <= CPU_ADDR;
                     mem_wdata_r <= CPU_WDATA;
                     state_r     <= ucs_pkg::ST_BYP;
                     busy_r      <= 1'b1;
                  end else if (hit0 || hit1) begin
                     cpu_ack_r   <= 1'b1;
                     cpu_rdata_r <= hit0 ? way_zero[{f_set(CPU_ADDR), CPU_ADDR[3:2]}]
                                         : way_one[{f_set(CPU_ADDR), CPU_ADDR[3:2]}];
                  end else begin
                     victim_r   <= one_way ? 1'b0 : victim_c;
                     ncs_r      <= ncs_c;
                     wcnt_r     <= 2'h0;
                     mem_req_r  <= 1'b1;
                     mem_we_r   <= 1'b0;
                     mem_addr_r <= {CPU_ADDR[31:4], 4'h0};
                     state_r    <= ucs_pkg::ST_FILL;
                     busy_r     <= 1'b1;
                  end
               end
            end
            ucs_pkg::ST_FILL: begin
               if (MEM_ACK) begin
                  if (victim_r) way_one[{f_set(addr_r), wcnt_r}] <= MEM_RDATA;
                  else way_zero[{f_set(addr_r), wcnt_r}] <= MEM_RDATA;
                  if (wcnt_r == addr_r[3:2]) cpu_rdata_r <= MEM_RDATA;
                  wcnt_r     <= wcnt_r + 2'h1;
                  mem_addr_r <= {addr_r[31:4], wcnt_r + 2'h1, 2'h0};
                  if (wcnt_r == 2'(ucs_pkg::LINE_WORDS - 1)) begin
                     mem_req_r <= 1'b0;
                     if (victim_r) tag1[f_set(addr_r)] <= f_tag(addr_r);
                     else tag0[f_set(addr_r)] <= f_tag(addr_r);
                     cs[f_set(addr_r)] <= ncs_r;
                     vld[f_set(addr_r)][victim_r] <= 1'b1;
                     state_r <= ucs_pkg::ST_DONE;
                  end
               end
            end
            ucs_pkg::ST_BYP: begin
               if (MEM_ACK) begin
                  mem_req_r   <= 1'b0;
                  mem_we_r    <= 1'b0;
                  cpu_rdata_r <= we_r ? 32'h0000_0000 : MEM_RDATA;
                  cpu_ack_r   <= 1'b1;
                  state_r     <= ucs_pkg::ST_IDLE;
                  busy_r      <= 1'b0;
               end
            end
            ucs_pkg::ST_DONE: begin
               cpu_ack_r <= 1'b1;
               state_r   <= ucs_pkg::ST_IDLE;
               busy_r    <= 1'b0;
            end
            default: begin
               state_r <= ucs_pkg::ST_IDLE;
               busy_r  <= 1'b0;
            end
         endcase
      end
   end

   assign REG_RDATA = reg_rdata_r;
   assign CPU_ACK   = cpu_ack_r;
   assign CPU_RDATA = cpu_rdata_r;
   assign CPU_BUSY  = busy_r;
   assign MEM_REQ   = mem_req_r;
   assign MEM_WE    = mem_we_r;
   assign MEM_ADDR  = mem_addr_r;
   assign MEM_WDATA = mem_wdata_r;
endmodule : ucs_cache

/* bench/ucs_cache_chk.sv */
// Checker holding the port assertions of the unified cache.
`timescale 1ns/1ps
module ucs_cache_chk #(
   parameter int unsigned LINES = ucs_pkg::NUM_LINES
) (
   input wire logic        CLK,
   input wire logic        RESET,
   input wire logic [3:0]  REG_ADDR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        CPU_REQ,
   input wire logic        CPU_ACK,
   input wire logic        CPU_BUSY,
   input wire logic        MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic        MEM_ACK
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   reg_idle_a: assert property ((!REG_RD || REG_ADDR != 4'h0) |=> REG_RDATA == 32'h0)
      else $error("stray read data");
   ack_pulse_a: assert property (CPU_ACK |=> !CPU_ACK)
      else $error("answer longer than one cycle");
   mem_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
      else $error("memory request dropped or moved");
   mem_step_a: assert property ((MEM_REQ && MEM_ACK) ##1 MEM_REQ
      |-> MEM_ADDR == $past(MEM_ADDR) + 32'h4)
      else $error("fill words out of order");
   fill_ack_a: assert property ((MEM_REQ && MEM_ACK) ##1 !MEM_REQ |-> ##[0:1] CPU_ACK)
      else $error("late answer after memory");
   hit_quiet_a: assert property (CPU_REQ && !CPU_BUSY && !CPU_ACK |=> CPU_ACK != MEM_REQ)
      else $error("request neither answered nor sent out");
   ack_alone_a: assert property (CPU_ACK |-> !MEM_REQ)
      else $error("answer while memory busy");
   clear_busy_a: assert property ($fell(RESET) |-> ##2 CPU_BUSY [*8])
      else $error("no tag clearing after reset");
endmodule : ucs_cache_chk
bind ucs_cache ucs_cache_chk #(.LINES(LINES)) u_chk (
   .CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .CPU_REQ(CPU_REQ), .CPU_ACK(CPU_ACK), .CPU_BUSY(CPU_BUSY),
   .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK)
);

/* bench/ucs_mem_model.sv */
// Behavioural external memory with random stalls.
`timescale 1ns/1ps
module ucs_mem_model (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        MEM_REQ,
   input  wire logic        MEM_WE,
   input  wire logic [31:0] MEM_ADDR,
   input  wire logic [31:0] MEM_WDATA,
   output logic             MEM_ACK,
   output logic [31:0]      MEM_RDATA
);
   int stall_r;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         MEM_ACK   <= 1'b0;
         MEM_RDATA <= 32'h0;
         stall_r   <= 0;
      end else if (MEM_REQ && !MEM_ACK && stall_r == 0) begin
         // Data follow the word address, so a wrong fill order shows up as wrong data.
         MEM_ACK   <= 1'b1;
         MEM_RDATA <= {MEM_ADDR[15:0], ~MEM_ADDR[15:0]};
         stall_r   <= $urandom_range(2, 0);
      end else begin
         // Between beats the data wander so that stale data never pass.
         MEM_ACK   <= 1'b0;
         MEM_RDATA <= ~MEM_RDATA;
         stall_r   <= stall_r == 0 ? 0 : stall_r - 1;
      end
   end
endmodule : ucs_mem_model

/* bench/ucs_cache_tb.sv */
// Self-checking testbench for the unified cache against a tag model.
`timescale 1ns/1ps
module ucs_cache_tb;
   logic        CLK       = 1'b0;
   logic        RESET     = 1'b1;
   logic [3:0]  REG_ADDR  = 4'h0;
   logic [31:0] REG_WDATA = 32'h0;
   logic        REG_WR    = 1'b0;
   logic        REG_RD    = 1'b0;
   logic        CPU_REQ   = 1'b0;
   logic        CPU_WE    = 1'b0;
   logic [31:0] CPU_ADDR  = 32'h0;
   logic [31:0] CPU_WDATA = 32'h0;
   logic [31:0] REG_RDATA, CPU_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, rd, a, wd, tb_a, mwd;
   logic        CPU_ACK, CPU_BUSY, MEM_REQ, MEM_WE, MEM_ACK;
   logic [7:0]  idx;
   int          num_errors = 0;
   int          checks_done = 0;
   int          n, k;
   int          cs [256];
   int          t0 [256];
   int          t1 [256];
   always #20 CLK = ~CLK;
   ucs_cache dut (
      .CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CPU_REQ(CPU_REQ), .CPU_WE(CPU_WE),
      .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA), .CPU_ACK(CPU_ACK), .CPU_RDATA(CPU_RDATA),
      .CPU_BUSY(CPU_BUSY), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
      .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA)
   );
   ucs_mem_model mem (
      .CLK(CLK), .RESET(RESET), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
      .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA)
   );
   task automatic report_and_stop();
      $display("Mismatches %0d, comparisons %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge CLK);
      #1;
   endtask : tick
   task automatic reg_op(input logic wr, input logic [3:0] ad, input logic [31:0] d);
      REG_ADDR  <= ad;
      REG_WDATA <= d;
      REG_WR    <= wr;
      REG_RD    <= !wr;
      tick();
      REG_WR    <= 1'b0;
      REG_RD    <= 1'b0;
      rd = REG_RDATA;
      tick();
   endtask : reg_op
   // Counts memory beats up to the answer; the extra cycle keeps requests out of ack cycles.
   task automatic cpu(input logic we, input logic [31:0] ad, input logic [31:0] d);
      int i;
      for (i = 0; i < 400 && CPU_BUSY !== 1'b0; i++) tick();
      if (i == 400) begin
         num_errors++;
         report_and_stop();
      end
      CPU_WE    <= we;
      CPU_ADDR  <= ad;
      CPU_WDATA <= d;
      CPU_REQ   <= 1'b1;
      tick();
      CPU_REQ   <= 1'b0;
      n = 0;
      for (i = 0; i < 400 && CPU_ACK !== 1'b1; i++) begin
         n += int'(MEM_REQ === 1'b1 && MEM_ACK === 1'b1);
         if (MEM_ACK === 1'b1 && MEM_WE === 1'b1) mwd = MEM_WDATA;
         tick();
      end
      rd = CPU_RDATA;
      if (i == 400) begin
         num_errors++;
         report_and_stop();
      end
      tick();
   endtask : cpu
   function automatic logic [31:0] mw(logic [31:0] ad);
      return {ad[15:0], ~ad[15:0]};
   endfunction : mw
   function automatic logic [31:0] tw(int i);
      return {cs[i] != 0, cs[i] >= 2, 15'(t1[i]), 15'(t0[i])};
   endfunction : tw
   // State 5 stands for set-state 01 once both ways hold data.
   function automatic int mdl(logic [31:0] ad);
      int i;
      int t;
      i = int'(ad[11:4]);
      t = int'(ad[26:12]);
      if ((cs[i] != 0 && t0[i] == t) || (cs[i] >= 2 && t1[i] == t)) return 0;
      case (cs[i])
         0: begin t0[i] = t; cs[i] = 1; end
         1: begin t1[i] = t; cs[i] = 3; end
         2: begin t1[i] = t; cs[i] = 5; end
         default: begin t0[i] = t; cs[i] = 2; end
      endcase
      return 4;
   endfunction : mdl
   initial begin
      void'($urandom(32'hC36DFA81));
      repeat (2) tick();
      RESET <= 1'b0;
      n = 0;
      for (k = 0; k < 400 && !(n > 0 && CPU_BUSY === 1'b0); k++) begin
         n += int'(CPU_BUSY === 1'b1);
         tick();
      end
      if (k == 400) begin
         num_errors++;
         report_and_stop();
      end
      chk(32'(n), 32'(ucs_pkg::NUM_LINES));
      reg_op(1'b0, 4'h0, 32'h0);
      chk(rd, ucs_pkg::CFG_RESET);
      reg_op(1'b1, 4'h9, $urandom);
      reg_op(1'b0, 4'h9, 32'h0);
      chk(rd, 32'h0);
      a = ({6'h00, 26'($urandom)} & 32'hFFFFFFF0) | 32'h0200_0000;
      for (k = 0; k < 2; k++) begin
         cpu(1'b0, a, 32'h0);
         chk(rd, mw(a));
         chk(32'(n), 32'h1);
      end
      for (k = 0; k < 8; k++) begin
         idx = k == 0 ? 8'hFF : 8'($urandom);
         cpu(1'b0, ucs_pkg::TAG_BASE | {idx, 2'h0}, 32'h0);
         chk(rd, 32'h0);
      end
      wd = (32'h1 << ucs_pkg::CFG_EN_BIT) | (32'(ucs_pkg::SIZE_8K) << ucs_pkg::CFG_SIZE_LO);
      reg_op(1'b1, 4'h0, wd);
      reg_op(1'b0, 4'h0, 32'h0);
      chk(rd, wd);
      idx = 8'($urandom);
      tb_a = ucs_pkg::TAG_BASE | {idx, 2'h0};
      for (k = 0; k < 5; k++) begin
         a = {5'h00, 15'(($urandom & 32'h3FFC) | k), idx, 2'(k), 2'h0};
         cpu(1'b0, a, 32'h0);
         chk(rd, mw(a));
         chk(32'(n), 32'(mdl(a)));
         cpu(1'b0, a ^ 32'h4, 32'h0);
         chk(rd, mw(a ^ 32'h4));
         chk(32'(n), 32'(mdl(a ^ 32'h4)));
         cpu(1'b0, tb_a, 32'h0);
         chk(rd, tw(idx));
      end
      cpu(1'b1, tb_a, 32'h0);
      cs[idx] = 0;
      cpu(1'b0, a, 32'h0);
      chk(32'(n), 32'(mdl(a)));
      a = a | 32'h0400_0000;
      for (k = 0; k < 2; k++) begin
         cpu(1'b0, a, 32'h0);
         chk(rd, mw(a));
         chk(32'(n), 32'h1);
      end
      wd = $urandom;
      mwd = ~wd;
      cpu(1'b1, a, wd);
      chk(mwd, wd);
      chk(32'(n), 32'h1);
      for (k = 0; k < 2; k++) begin
         a = (k == 0 ? ucs_pkg::WAY0_BASE : ucs_pkg::WAY1_BASE) | 32'hFFC;
         wd = $urandom;
         cpu(1'b1, a, wd);
         cpu(1'b0, a, 32'h0);
         chk(rd, wd);
      end
      wd = (32'h1 << ucs_pkg::CFG_EN_BIT) | (32'($urandom_range(1023, 1)) << 6);
      reg_op(1'b1, 4'h0, wd);
      for (k = 0; k < 256; k++) cpu(1'b1, ucs_pkg::TAG_BASE | (32'(k) << 2), 32'h0);
      for (k = 0; k < 4; k++) begin
         a = {6'h00, wd[15:6], 16'h0000} | (k[0] ? 32'h0000_1FFC : 32'h0000_0FFC);
         cpu(k < 2, a, ~a);
         chk(k < 2 ? 32'(n) : rd, k < 2 ? 32'h0 : ~a);
      end
      report_and_stop();
   end
endmodule : ucs_cache_tb
